//--- logic/tx_ctrl_pkg.sv
// Constants, types and defaults for the transmit-cycle controller.
// Assumes a 100 MHz system clock driving all logic.
package tx_ctrl_pkg;

    // Clock rate and documented times
    localparam int CLK_MHZ       = 100;
    localparam int WARMUP_US     = 400;
    localparam int SETTLE_US     = 370;
    localparam int MS_US         = 1000;
    localparam int US_CYCLES     = CLK_MHZ;
    localparam int WARMUP_CYCLES = WARMUP_US * US_CYCLES;
    localparam int SETTLE_CYCLES = SETTLE_US * US_CYCLES;
    localparam int MS_CYCLES     = MS_US * US_CYCLES;

    // Widths
    localparam int TIMER_W    = 17;
    localparam int US_W       = 7;
    localparam int MS_W       = 7;
    localparam int RAMP_W     = 11;
    localparam int LEVEL_W    = 8;
    localparam int FREQ_W     = 20;
    localparam int POWER_W    = 5;
    localparam int STOP_W     = 4;
    localparam int RAMP_SEL_W = 4;
    localparam int FIELDS     = 7;
    localparam int FIFO_DEPTH = 8;
    localparam int FIFO_WIDTH = 1;

    // Working states, one-hot
    typedef enum logic [3:0] {
        ST_SLEEP    = 4'h1,
        ST_WARMUP   = 4'h2,
        ST_SETTLE   = 4'h4,
        ST_TRANSMIT = 4'h8
    } state_type;

    // Modulation choices
    typedef enum logic [1:0] {
        MOD_FSK  = 2'h0,
        MOD_GFSK = 2'h1,
        MOD_OOK  = 2'h2
    } mod_type;

    // Bit positions in the field write mask
    localparam int F_MOD    = 0;
    localparam int F_INVERT = 1;
    localparam int F_RAMP   = 2;
    localparam int F_START  = 3;
    localparam int F_STOP   = 4;
    localparam int F_FREQ   = 5;
    localparam int F_POWER  = 6;

    // Reset defaults and limits
    localparam logic                  INVERT_DEFAULT = 1'b0;
    localparam logic [RAMP_SEL_W-1:0] RAMP_DEFAULT   = 4'h0;
    localparam logic [RAMP_SEL_W-1:0] RAMP_SEL_MAX   = 4'hb;
    localparam logic                  FALLING_DEFAULT = 1'b0;
    localparam logic [STOP_W-1:0]     STOP_DEFAULT   = 4'h8;
    localparam logic [STOP_W-1:0]     STOP_LONG_SEL  = 4'h8;
    localparam logic [MS_W-1:0]       STOP_SHORT_MS  = 7'h02;
    localparam logic [MS_W-1:0]       STOP_LONG_MS   = 7'h14;
    localparam logic [MS_W-1:0]       STOP_STEP_MS   = 7'h0a;
    localparam logic [FREQ_W-1:0]     FREQ_MIN_KHZ   = 20'h3a980;
    localparam logic [FREQ_W-1:0]     FREQ_MAX_KHZ   = 20'hea600;
    localparam logic [FREQ_W-1:0]     FREQ_DEFAULT   = 20'hd3ffe;
    localparam logic [POWER_W-1:0]    POWER_MAX      = 5'h17;
    localparam logic [POWER_W-1:0]    POWER_DEFAULT  = 5'h17;
    localparam logic [LEVEL_W-1:0]    LEVEL_FULL     = 8'hff;
    localparam logic [LEVEL_W-1:0]    LEVEL_ZERO     = 8'h00;
    localparam int                    RAMP_TOP_BIT   = 10;

endpackage

//--- logic/sym_fifo.sv
// Small first-in first-out buffer with registered output stage.
// Assumes DEPTH is a power of two; one clock, synchronous reset.
`timescale 1ns/10ps
module sym_fifo
    import tx_ctrl_pkg::*;
#(
    parameter int WIDTH = FIFO_WIDTH,
    parameter int DEPTH = FIFO_DEPTH
) (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    output logic                  out_valid,
    output logic      [WIDTH-1:0] out_data,
    input  wire logic             out_ready
);
    localparam int PTR_W = $clog2(DEPTH);
    localparam int CNT_W = $clog2(DEPTH + 1);

    // Whole buffer state
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;       // Storage entries
        logic [PTR_W-1:0]            wr;        // Write index
        logic [PTR_W-1:0]            rd;        // Read index
        logic [CNT_W-1:0]            count;     // Entries held
        logic                        out_valid; // Output stage full
        logic [WIDTH-1:0]            out_data;  // Output stage word
    } fifo_state_type;

    fifo_state_type r;
    fifo_state_type next_r;
    logic           push;
    logic           pop;

    // Full is honest: no room once DEPTH entries are held
    assign in_ready  = (r.count != CNT_W'(DEPTH));
    assign out_valid = r.out_valid;
    assign out_data  = r.out_data;

    // Next-state logic
    always_comb begin
        next_r = r;
        push   = in_valid && in_ready;
        pop    = (r.count != '0) && (!r.out_valid || out_ready);
        // Output stage empties when taken
        if (out_ready) begin
            next_r.out_valid = 1'b0;
        end
        // Refill output stage from storage
        if (pop) begin
            next_r.out_data  = r.mem[r.rd];
            next_r.out_valid = 1'b1;
            next_r.rd        = PTR_W'(r.rd + 1'b1);
        end
        // Store incoming word
        if (push) begin
            next_r.mem[r.wr] = in_data;
            next_r.wr        = PTR_W'(r.wr + 1'b1);
        end
        // Occupancy tracking
        if (push && !pop) begin
            next_r.count = CNT_W'(r.count + 1'b1);
        end else if (pop && !push) begin
            next_r.count = CNT_W'(r.count - 1'b1);
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (reset) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

endmodule // sym_fifo

//--- logic/tx_state_control.sv
// Transmit-cycle controller: sleep, warm-up, settle, transmit.
// Assumes data_pin is asynchronous; commands and config inputs are
// one-cycle pulses from logic on clk.
`timescale 1ns/10ps
module tx_state_control
    import tx_ctrl_pkg::*;
#(
    parameter int WARMUP_CYC = WARMUP_CYCLES,
    parameter int SETTLE_CYC = SETTLE_CYCLES,
    parameter int MS_CYC     = MS_CYCLES
) (
    input  wire logic                  clk,
    input  wire logic                  reset,
    input  wire logic                  data_pin,
    input  wire logic                  serial_port_reset_command,
    input  wire logic                  serial_port_release_command,
    input  wire logic                  soft_reset_command,
    input  wire logic                  eeprom_load,
    input  wire logic                  host_write,
    input  wire logic [FIELDS-1:0]     host_write_mask,
    input  wire logic [1:0]            new_modulation,
    input  wire logic                  new_invert,
    input  wire logic [RAMP_SEL_W-1:0] new_ramp_sel,
    input  wire logic                  new_start_falling,
    input  wire logic [STOP_W-1:0]     new_stop_sel,
    input  wire logic [FREQ_W-1:0]     new_freq_khz,
    input  wire logic [POWER_W-1:0]    new_power_code,
    input  wire logic                  symbol_ready,
    output logic                       symbol_valid,
    output logic                       symbol_bit,
    output logic [3:0]                 state_code,
    output logic                       osc_enable,
    output logic                       synth_enable,
    output logic                       pa_enable,
    output logic [LEVEL_W-1:0]         pa_level,
    output logic [1:0]                 modulation,
    output logic [FREQ_W-1:0]          freq_khz,
    output logic [POWER_W-1:0]         power_code,
    output logic                       triggers_blocked,
    output logic                       config_loaded
);

    // Whole controller state
    typedef struct packed {
        state_type              state;     // Working state
        logic                   pin_meta;  // Synchroniser stage one
        logic                   pin_sync;  // Synchroniser stage two
        logic                   pin_prev;  // For edge detection
        logic                   blocked;   // Edge triggers disabled
        mod_type                mod;       // Modulation
        logic                   invert;    // Data polarity
        logic [RAMP_SEL_W-1:0]  ramp_sel;  // Ramp option
        logic                   falling;   // Start on falling edge
        logic [STOP_W-1:0]      stop_sel;  // Stop time option
        logic [FREQ_W-1:0]      freq;      // Carrier in kHz
        logic [POWER_W-1:0]     power;     // Power code, 0 = -10 dBm
        logic                   loaded;    // Image copied in
        logic [TIMER_W-1:0]     timer;     // Phase and ms prescaler
        logic [MS_W-1:0]        low_ms;    // Whole ms of low pin
        logic [US_W-1:0]        us_div;    // Microsecond prescaler
        logic [RAMP_W-1:0]      ramp;      // Ramp position in us
        logic                   osc_en;    // Oscillator enable
        logic                   synth_en;  // Synthesizer enable
        logic                   pa_en;     // PA enable
        logic [LEVEL_W-1:0]     level;     // PA drive level
        logic                   push;      // Sample waiting for FIFO
        logic                   sample;    // Sampled symbol
    } ctrl_state_type;

    ctrl_state_type     r;
    ctrl_state_type     next_r;
    logic               fifo_ready;      // FIFO has room
    logic               rise;            // Rising edge seen
    logic               fall;            // Falling edge seen
    logic               us_tick;         // One microsecond elapsed
    logic               ms_tick;         // One millisecond elapsed
    logic [MS_W-1:0]    stop_ms;         // Selected stop time
    logic [RAMP_W-1:0]  ramp_us;         // Selected ramp length
    logic               end_tx;          // Transmit ends now

    // Stop option to milliseconds
    function automatic logic [MS_W-1:0] stop_to_ms(
        input logic [STOP_W-1:0] sel
    );
        logic [MS_W-1:0] steps;
        steps = MS_W'(sel - STOP_LONG_SEL);
        if (sel < STOP_LONG_SEL) begin
            stop_to_ms = MS_W'(STOP_SHORT_MS + MS_W'(sel));
        end else begin
            stop_to_ms = MS_W'(STOP_LONG_MS + MS_W'(steps * STOP_STEP_MS));
        end
    endfunction

    // Ramp position to PA level, scaled to full span
    function automatic logic [LEVEL_W-1:0] ramp_level(
        input logic [RAMP_W-1:0]     pos,
        input logic [RAMP_SEL_W-1:0] sel
    );
        logic [RAMP_W-1:0] norm;
        norm = RAMP_W'(pos << (RAMP_SEL_MAX - sel));
        if (norm[RAMP_TOP_BIT]) begin
            ramp_level = LEVEL_FULL;
        end else begin
            ramp_level = norm[RAMP_TOP_BIT-1 -: LEVEL_W];
        end
    endfunction

    // Configuration write under a field mask
    function automatic ctrl_state_type apply_cfg(
        input ctrl_state_type  s,
        input logic [FIELDS-1:0] mask
    );
        apply_cfg = s;
        if (mask[F_MOD] && new_modulation != 2'h3) begin
            apply_cfg.mod = mod_type'(new_modulation);
        end
        if (mask[F_INVERT]) begin
            apply_cfg.invert = new_invert;
        end
        // ramp options up to 1024 us
        if (mask[F_RAMP] && new_ramp_sel <= RAMP_SEL_MAX) begin
            apply_cfg.ramp_sel = new_ramp_sel;
        end
        if (mask[F_START]) begin
            apply_cfg.falling = new_start_falling;
        end
        if (mask[F_STOP]) begin
            apply_cfg.stop_sel = new_stop_sel;
        end
        if (mask[F_FREQ] && new_freq_khz >= FREQ_MIN_KHZ
            && new_freq_khz <= FREQ_MAX_KHZ) begin
            apply_cfg.freq = new_freq_khz;
        end
        if (mask[F_POWER] && new_power_code <= POWER_MAX) begin
            apply_cfg.power = new_power_code;
        end
    endfunction

    // Symbol buffer toward the modulator
    sym_fifo #(
        .WIDTH (FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .reset     (reset),
        .in_valid  (r.push),
        .in_data   (r.sample),
        .in_ready  (fifo_ready),
        .out_valid (symbol_valid),
        .out_data  (symbol_bit),
        .out_ready (symbol_ready)
    );

    // Outputs straight from state flops
    assign state_code       = r.state;
    assign osc_enable       = r.osc_en;
    assign synth_enable     = r.synth_en;
    assign pa_enable        = r.pa_en;
    assign pa_level         = r.level;
    assign modulation       = r.mod;
    assign freq_khz         = r.freq;
    assign power_code       = r.power;
    assign triggers_blocked = r.blocked;
    assign config_loaded    = r.loaded;

    // Next-state logic
    always_comb begin
        next_r  = r;
        rise    = r.pin_sync && !r.pin_prev;
        fall    = !r.pin_sync && r.pin_prev;
        us_tick = (r.us_div == US_W'(US_CYCLES - 1));
        ms_tick = (r.timer == TIMER_W'(MS_CYC - 1));
        stop_ms = stop_to_ms(r.stop_sel);
        ramp_us = (r.ramp_sel == RAMP_DEFAULT) ? '0
                : RAMP_W'(1 << (r.ramp_sel - 1'b1));
        end_tx  = 1'b0;
        // Two-flop synchroniser and edge history
        next_r.pin_meta = data_pin;
        next_r.pin_sync = r.pin_meta;
        next_r.pin_prev = r.pin_sync;
        if (eeprom_load) begin
            next_r        = apply_cfg(next_r, '1);
            next_r.loaded = 1'b1;
        end
        if (host_write) begin
            next_r = apply_cfg(next_r, host_write_mask);
        end
        if (serial_port_reset_command) begin
            next_r.blocked = 1'b1;
        end else if (serial_port_release_command) begin
            next_r.blocked = 1'b0;
        end
        // FIFO accepted the waiting sample
        if (r.push && fifo_ready) begin
            next_r.push = 1'b0;
        end
        case (r.state)
            ST_SLEEP: begin
                next_r.osc_en   = 1'b0;
                next_r.synth_en = 1'b0;
                next_r.pa_en    = 1'b0;
                next_r.level    = LEVEL_ZERO;
                next_r.timer    = '0;
                if (!r.blocked && (r.falling ? fall : rise)) begin
                    next_r.state  = ST_WARMUP;
                    next_r.osc_en = 1'b1;
                end
            end
            ST_WARMUP: begin
                next_r.timer = TIMER_W'(r.timer + 1'b1);
                if (r.timer == TIMER_W'(WARMUP_CYC - 1)) begin
                    next_r.state    = ST_SETTLE;
                    next_r.synth_en = 1'b1;
                    next_r.timer    = '0;
                end
            end
            ST_SETTLE: begin
                // pin level not looked at here
                next_r.timer = TIMER_W'(r.timer + 1'b1);
                if (r.timer == TIMER_W'(SETTLE_CYC - 1)) begin
                    next_r.state  = ST_TRANSMIT;
                    next_r.pa_en  = 1'b1;
                    next_r.timer  = '0;
                    next_r.low_ms = '0;
                    next_r.us_div = '0;
                    next_r.ramp   = '0;
                    next_r.level  = (r.mod == MOD_OOK) ? LEVEL_ZERO
                                                       : LEVEL_FULL;
                end
            end
            ST_TRANSMIT: begin
                next_r.us_div = us_tick ? '0 : US_W'(r.us_div + 1'b1);
                // stop timer restarts on high pin
                if (r.pin_sync) begin
                    next_r.timer  = '0;
                    next_r.low_ms = '0;
                end else if (ms_tick) begin
                    next_r.timer  = '0;
                    next_r.low_ms = MS_W'(r.low_ms + 1'b1);
                end else begin
                    next_r.timer = TIMER_W'(r.timer + 1'b1);
                end
                if (us_tick && !r.push) begin
                    next_r.push   = 1'b1;
                    next_r.sample = (r.mod == MOD_OOK) ? r.pin_sync
                                  : (r.pin_sync ^ r.invert);
                end
                if (r.mod != MOD_OOK) begin
                    next_r.level = LEVEL_FULL;
                end else if (r.ramp_sel == RAMP_DEFAULT) begin
                    // zero ramp jumps straight to level
                    next_r.level = r.pin_sync ? LEVEL_FULL : LEVEL_ZERO;
                end else begin
                    if (us_tick && r.pin_sync && r.ramp < ramp_us) begin
                        next_r.ramp = RAMP_W'(r.ramp + 1'b1);
                    end else if (us_tick && !r.pin_sync
                                 && r.ramp != '0) begin
                        next_r.ramp = RAMP_W'(r.ramp - 1'b1);
                    end
                    next_r.level = ramp_level(next_r.ramp, r.ramp_sel);
                end
                // low for the stop time ends transmit
                if (r.low_ms >= stop_ms) begin
                    end_tx = 1'b1;
                end
            end
            default: begin
                end_tx = 1'b1;
            end
        endcase
        // soft reset stops the cycle at once
        if (soft_reset_command && r.state != ST_SLEEP) begin
            end_tx = 1'b1;
        end
        // PA off, sleep, edge detection re-armed
        if (end_tx) begin
            next_r.state    = ST_SLEEP;
            next_r.osc_en   = 1'b0;
            next_r.synth_en = 1'b0;
            next_r.pa_en    = 1'b0;
            next_r.level    = LEVEL_ZERO;
            next_r.timer    = '0;
            next_r.pin_prev = r.pin_sync;
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (reset) begin
            r          <= '0;
            // Synchroniser keeps running so release sees no false edge
            r.pin_meta <= data_pin;
            r.pin_sync <= r.pin_meta;
            r.pin_prev <= r.pin_sync;
            r.state    <= ST_SLEEP;
            r.mod      <= MOD_FSK;
            r.invert   <= INVERT_DEFAULT;
            r.ramp_sel <= RAMP_DEFAULT;
            r.falling  <= FALLING_DEFAULT;
            r.stop_sel <= STOP_DEFAULT;
            r.freq     <= FREQ_DEFAULT;
            r.power    <= POWER_DEFAULT;
        end else begin
            r <= next_r;
        end
    end

    // Checks on the controller
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    state_onehot_a: assert property (
        $onehot(r.state))
        else $error("state not one-hot");

    sleep_off_a: assert property (
        r.state == ST_SLEEP |-> !r.osc_en && !r.synth_en && !r.pa_en)
        else $error("block powered in sleep");

    wake_edge_a: assert property (
        r.state == ST_SLEEP && !r.blocked && !r.falling && rise
        |=> r.state == ST_WARMUP && r.osc_en)
        else $error("rising edge did not wake");

    edge_select_a: assert property (
        r.state == ST_SLEEP && r.falling && rise && !fall
        |=> r.state == ST_SLEEP)
        else $error("wrong edge woke controller");

    settle_exit_a: assert property (
        r.state == ST_SETTLE && r.timer == TIMER_W'(SETTLE_CYC - 1)
        && !soft_reset_command |=> r.state == ST_TRANSMIT && r.pa_en)
        else $error("settle did not end on time");

    pa_gate_a: assert property (
        r.state != ST_TRANSMIT |-> !r.pa_en && r.level == LEVEL_ZERO)
        else $error("PA on outside transmit");

    stop_time_a: assert property (
        r.state == ST_TRANSMIT && !r.pin_sync
        && r.low_ms == stop_ms |=> r.state == ST_SLEEP)
        else $error("stop time not honoured");

    soft_stop_a: assert property (
        soft_reset_command && r.state == ST_TRANSMIT
        |=> r.state == ST_SLEEP && !r.pa_en)
        else $error("soft reset did not stop");

    fsk_level_a: assert property (
        r.pa_en && r.mod != MOD_OOK |-> r.level == LEVEL_FULL)
        else $error("ramp used outside OOK");

    ramp_zero_a: assert property (
        r.state == ST_TRANSMIT && $past(r.state) == ST_TRANSMIT
        && r.mod == MOD_OOK && r.ramp_sel == RAMP_DEFAULT
        |-> r.level == ($past(r.pin_sync) ? LEVEL_FULL : LEVEL_ZERO))
        else $error("zero ramp not immediate");

    block_hold_a: assert property (
        r.blocked && r.state == ST_SLEEP |=> r.state == ST_SLEEP)
        else $error("blocked trigger woke controller");

    wake_c: cover property (r.state == ST_SLEEP ##1 r.state == ST_WARMUP);
    tx_c: cover property (r.state == ST_SETTLE ##1 r.state == ST_TRANSMIT);
    stop_c: cover property (r.state == ST_TRANSMIT ##1 r.state == ST_SLEEP);
    full_c: cover property (r.push && !fifo_ready);

endmodule // tx_state_control

//--- test/sym_sink.sv
// Modulator stand-in that takes symbols from the controller's FIFO.
// Assumes one clock; stall holds ready low so the FIFO fills up.
`timescale 1ns/10ps
module sym_sink (
    input  wire logic clk,
    input  wire logic stall,
    input  wire logic symbol_valid,
    output logic      symbol_ready
);
    // Ready is the inverse of stall, one edge later
    always_ff @(posedge clk) begin
        symbol_ready <= !stall;
    end
endmodule // sym_sink

//--- test/tx_state_control_test.sv
// Self-checking bench for the transmit-cycle controller.
// Assumes shortened counts: 20 warm-up, 20 settle, 50 cycles per ms.
`timescale 1ns/10ps
module tx_state_control_test;
    import tx_ctrl_pkg::*;
    logic clk = 0, reset = 1, data_pin = 0, stall = 0;
    logic serial_port_reset_command = 0, serial_port_release_command = 0;
    logic soft_reset_command = 0, eeprom_load = 0, host_write = 0;
    logic [FIELDS-1:0]     host_write_mask = '0;
    logic [1:0]            new_modulation = 2'h0;
    logic                  new_invert = 1'b0, new_start_falling = 1'b0;
    logic [RAMP_SEL_W-1:0] new_ramp_sel = 4'h0;
    logic [STOP_W-1:0]     new_stop_sel = 4'h8;
    logic [FREQ_W-1:0]     new_freq_khz = 20'h0;
    logic [POWER_W-1:0]    new_power_code = 5'h0;
    logic symbol_ready, symbol_valid, symbol_bit, osc_enable, synth_enable;
    logic pa_enable, triggers_blocked, config_loaded;
    logic [3:0]            state_code;
    logic [LEVEL_W-1:0]    pa_level;
    logic [1:0]            modulation;
    logic [FREQ_W-1:0]     freq_khz;
    logic [POWER_W-1:0]    power_code;
    int errors = 0, n_tests = 0, cycles = 0, n;
    tx_state_control #(.WARMUP_CYC(20), .SETTLE_CYC(20), .MS_CYC(50))
        tx_state_control_i (.*);
    sym_sink sym_sink_i (.clk, .stall, .symbol_valid, .symbol_ready);
    // Clock and hang guard
    initial forever #5 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            summarize();
        end
    end
    task summarize;
        if (errors == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input string s, input logic [19:0] e, input logic [19:0] g);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", s, e, g);
        end
    endtask
    task cyc(input int k);
        repeat (k) @(negedge clk);
    endtask
    // Bounded wait for a state, cycles spent left in n
    task wst(input logic [3:0] s, input int lim);
        n = 0;
        while (state_code !== s && n < lim) begin
            cyc(1);
            n++;
        end
        chk("state", s, state_code);
    endtask
    task wr(input logic [6:0] m, input logic [3:0] st, input logic [19:0] f,
            input logic [4:0] p);
        host_write_mask = m;
        new_stop_sel = st;
        new_freq_khz = f;
        new_power_code = p;
        host_write = 1;
        cyc(1);
        host_write = 0;
        cyc(1);
    endtask
    // Start edge through warm-up and settle into transmit
    task wake(input logic p, input logic [LEVEL_W-1:0] lv);
        data_pin = p;
        wst(ST_WARMUP, 6);
        chk("osc", 1, osc_enable);
        wst(ST_SETTLE, 25);
        chk("warmup", 1, n > 17 && n < 23);
        chk("synth_pa", 2'b10, {synth_enable, pa_enable});
        wst(ST_TRANSMIT, 25);
        chk("settle", 1, n > 17 && n < 23);
        chk("level", lv, pa_level);
    endtask
    // Power-up image load, then host rewrite of one field
    task t_load;
        new_modulation = 2'h2;
        eeprom_load = 1;
        cyc(1);
        eeprom_load = 0;
        new_modulation = 2'h0;
        cyc(1);
        chk("load", 8'hc0, {config_loaded, modulation, power_code});
        chk("load_freq", FREQ_DEFAULT, freq_khz);
        wr(7'h01, 4'h8, 20'h0, 5'h0);
        chk("rewrite", 3'h4, {config_loaded, modulation});
    endtask
    // Transmit with sink stalled, then stop by holding the pin low
    task t_stop(input logic [3:0] sel, input int ms, input logic inv);
        new_invert = inv;
        wr(7'h12, sel, 20'h0, 5'h0);
        stall = 1;
        wake(1'b1, LEVEL_FULL);
        cyc(1000);
        chk("sym", {1'b1, !inv}, {symbol_valid, symbol_bit});
        stall = 0;
        data_pin = 0;
        wst(ST_SLEEP, ms * 50 + 20);
        chk("stop", 1, n > ms * 50 - 5);
        chk("off", 0, {osc_enable, synth_enable, pa_enable, pa_level});
    endtask
    task t_cfg;
        wr(7'h60, 4'h8, 20'h3a980, 5'h00);
        chk("freq", 20'h3a980, freq_khz);
        wr(7'h60, 4'h8, 20'hea601, 5'h18);
        chk("freq_bad", 20'h3a980, freq_khz);
        chk("power", 5'h00, power_code);
    endtask
    // Port reset blocks wake, release re-enables, soft reset ends transmit
    task t_block;
        serial_port_reset_command = 1;
        cyc(1);
        serial_port_reset_command = 0;
        data_pin = 1;
        cyc(8);
        chk("blocked", 5'h11, {triggers_blocked, state_code});
        data_pin = 0;
        serial_port_release_command = 1;
        cyc(1);
        serial_port_release_command = 0;
        cyc(3);
        wake(1'b1, LEVEL_FULL);
        soft_reset_command = 1;
        cyc(1);
        soft_reset_command = 0;
        cyc(1);
        chk("soft", 5'h01, {pa_enable, state_code});
        data_pin = 0;
        cyc(4);
    endtask
    // OOK with a 2 us ramp, falling-edge start, 4 ms stop
    task t_ook;
        new_modulation = 2'h2;
        new_ramp_sel = 4'h2;
        new_start_falling = 1;
        wr(7'h1d, 4'h2, 20'h0, 5'h0);
        data_pin = 1;
        cyc(6);
        chk("no_rise", 4'h1, state_code);
        wake(1'b0, LEVEL_ZERO);
        data_pin = 1;
        cyc(150);
        chk("ramp_up", 8'h80, pa_level);
        cyc(100);
        chk("ramp_top", LEVEL_FULL, pa_level);
        data_pin = 0;
        cyc(100);
        chk("ramp_down", 8'h80, pa_level);
        wst(ST_SLEEP, 250);
        chk("ook_off", 0, {pa_enable, pa_level});
    endtask
    initial begin
        cyc(4);
        reset = 0;
        cyc(3);
        chk("rst", 5'h01, {osc_enable, state_code});
        chk("dflt", {FREQ_DEFAULT}, freq_khz);
        chk("mod", {MOD_FSK, POWER_DEFAULT}, {modulation, power_code});
        t_load();
        t_cfg();
        t_stop(4'h8, 20, 1'b0);
        t_stop(4'h0, 2, 1'b0);
        t_stop(4'h7, 9, 1'b1);
        t_block();
        t_ook();
        summarize();
    end
endmodule // tx_state_control_test
